// ===== inc/prsd_cfg.svh
`ifndef PRSD_CFG_SVH
`define PRSD_CFG_SVH

// I/O window for forwarded normal registers
`define PRSD_IO_BASE     32'hE100_0000
`define PRSD_IO_NUM_LO   2
`define PRSD_NORMAL_CNT  256

// Group-selecting address bits
`define PRSD_GRP_BIT     24
`define PRSD_SUB_HI      23
`define PRSD_SUB_LO      22
`define PRSD_SUB_L2TAG   2'h0
`define PRSD_SUB_L2DEAL  2'h1
`define PRSD_SUB_L1TAG   2'h2
`define PRSD_SUB_L1PAR   2'h3

// Entry index fields per group
`define PRSD_L2_IDX_HI   20
`define PRSD_L2_IDX_LO   5
`define PRSD_L1T_IDX_HI  12
`define PRSD_L1T_IDX_LO  5
`define PRSD_L1P_IDX_HI  12
`define PRSD_L1P_IDX_LO  3

// One-hot group select positions
`define PRSD_G_NORMAL    0
`define PRSD_G_L2TAG     1
`define PRSD_G_L2DEAL    2
`define PRSD_G_L1TAG     3
`define PRSD_G_L1PAR     4

// Category classes
`define PRSD_CLS_EXT     2'h3

// Reset values
`define PRSD_ZERO32      32'h0000_0000

`endif

// ===== inc/prsd_pkg.sv
`include "prsd_cfg.svh"

package prsd_pkg;

   typedef struct packed {
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } prsd_req_t;

   typedef struct packed {
      logic [1:0] cls;
      logic [2:0] sub;
   } prsd_cat_t;

   typedef struct packed {
      logic [4:0]  grp;
      logic        fwd;
      logic [7:0]  num;
      logic [15:0] idx;
      logic [31:0] io_addr;
   } prsd_dec_t;

   typedef struct packed {
      logic        write;
      logic        mmu;
      logic [4:0]  grp;
      logic [7:0]  num;
      logic [15:0] idx;
      logic [31:0] wdata;
   } prsd_icmd_t;

   typedef struct packed {
      logic        write;
      logic [31:0] addr;
      logic [31:0] data;
   } prsd_bus_t;

endpackage

// ===== design/prsd_group_sel.sv
`timescale 1ns/1ns
`include "prsd_cfg.svh"
module prsd_group_sel
   import prsd_pkg::*;
(
   // Register address
   input  wire logic [31:0] addr_in,
   // Decode
   output logic      [4:0]  grp_out,
   output logic      [15:0] idx_out
);
   wire       is_grp = addr_in[`PRSD_GRP_BIT];
   wire [1:0] sub    = addr_in[`PRSD_SUB_HI:`PRSD_SUB_LO];
   wire [15:0] l2_idx  = addr_in[`PRSD_L2_IDX_HI:`PRSD_L2_IDX_LO];
   wire [7:0]  l1t_idx = addr_in[`PRSD_L1T_IDX_HI:`PRSD_L1T_IDX_LO];
   wire [9:0]  l1p_idx = addr_in[`PRSD_L1P_IDX_HI:`PRSD_L1P_IDX_LO];

   // Gaps between ranges fall into a group too; no zero
   assign grp_out[`PRSD_G_NORMAL] = !is_grp;
   assign grp_out[`PRSD_G_L2TAG]  = is_grp && (sub == `PRSD_SUB_L2TAG);
   assign grp_out[`PRSD_G_L2DEAL] = is_grp && (sub == `PRSD_SUB_L2DEAL);
   assign grp_out[`PRSD_G_L1TAG]  = is_grp && (sub == `PRSD_SUB_L1TAG);
   assign grp_out[`PRSD_G_L1PAR]  = is_grp && (sub == `PRSD_SUB_L1PAR);

   // Bit 7 of the tag index and bit 9 of the parity index pick the set
   assign idx_out = grp_out[`PRSD_G_L1PAR] ? {6'h00, l1p_idx} :
                    grp_out[`PRSD_G_L1TAG] ? {8'h00, l1t_idx} :
                    is_grp                 ? l2_idx : 16'h0000;
endmodule

// ===== design/prsd_class_lut.sv
`timescale 1ns/1ns
module prsd_class_lut
   import prsd_pkg::*;
(
   // Normal register number
   input  wire logic [7:0] num_in,
   // Category
   output prsd_cat_t       cat_out
);
   function automatic prsd_cat_t lookup(input logic [7:0] n);
      prsd_cat_t c;
      c = '{cls: 2'h3, sub: 3'h0};
      case (n) inside
         [8'h00:8'h04], [8'h10:8'h15], 8'h39, 8'h3A, 8'h3E, 8'h3F:
            c = '{cls: 2'h1, sub: 3'h1};
         [8'h08:8'h0D], 8'h38:
            c = '{cls: 2'h1, sub: 3'h2};
         8'h0E, 8'h26, 8'h2A, 8'h2B, [8'h7A:8'h7F]:
            c = '{cls: 2'h2, sub: 3'h1};
         8'h18:
            c = '{cls: 2'h2, sub: 3'h7};
         8'h19, 8'h1A:
            c = '{cls: 2'h3, sub: 3'h7};
         [8'h1B:8'h23], 8'h37, [8'h40:8'h44]:
            c = '{cls: 2'h2, sub: 3'h3};
         [8'h64:8'h66]:
            c = '{cls: 2'h2, sub: 3'h4};
         8'hA0, [8'hA2:8'hA8], 8'hAB, 8'hAC, 8'hAE, 8'hB0, 8'hB2, 8'hB4,
         8'hB6, 8'hB8, [8'hD0:8'hD4], 8'hD6, 8'hD7, [8'hE0:8'hEA], 8'hEC,
         8'hED, 8'hF2, 8'hF4, 8'hF8:
            c = '{cls: 2'h2, sub: 3'h5};
         8'hA1, 8'hA9, 8'hAA, 8'hAD, 8'hAF, 8'hB1, 8'hB3, 8'hB5, 8'hB7,
         [8'hB9:8'hCF], 8'hD5, [8'hD8:8'hDF], 8'hEB, [8'hEE:8'hF1], 8'hF3,
         [8'hF5:8'hF7], [8'hF9:8'hFF]:
            c = '{cls: 2'h2, sub: 3'h6};
         default:
            c = '{cls: 2'h3, sub: 3'h0};
      endcase
      return c;
   endfunction

   assign cat_out = lookup(num_in);
endmodule

// ===== design/prsd_decoder.sv
`timescale 1ns/1ns
`include "prsd_cfg.svh"
module prsd_decoder
   import prsd_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   // Option strap pin
   input  wire logic        vm_opt_in,
   // Register reference request
   input  wire logic        req_valid_in,
   output logic             req_ready_out,
   input  wire prsd_req_t   req_in,
   // Completion
   output logic             done_out,
   output logic      [31:0] rdata_out,
   output logic             rsvd_hit_out,
   // Decode result
   output logic             dec_valid_out,
   output prsd_dec_t        dec_out,
   // Microcode path
   output logic             ucode_valid_out,
   output logic      [7:0]  ucode_num_out,
   input  wire logic        ucode_done_in,
   input  wire logic [31:0] ucode_rdata_in,
   // Internal command path
   output logic             icmd_valid_out,
   output prsd_icmd_t       icmd_out,
   input  wire logic        icmd_done_in,
   input  wire logic [31:0] icmd_rdata_in,
   // System bus command
   output logic             bus_valid_out,
   output prsd_bus_t        bus_out,
   input  wire logic        bus_ready_in,
   input  wire logic        bus_rsp_valid_in,
   input  wire logic [31:0] bus_rsp_data_in
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ROUTE,
      ST_UCODE,
      ST_ICMD,
      ST_BUS,
      ST_RSP,
      ST_DONE
   } prsd_state_t;

   prsd_state_t state_r;
   prsd_state_t state_nxt;

   // Strap synchroniser; value moves only when stages two and three agree
   logic vm_s1_r;
   logic vm_s2_r;
   logic vm_s3_r;
   logic vm_opt_r;
   wire  vm_agree = (vm_s2_r == vm_s3_r);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         vm_s1_r <= 1'b0;
         vm_s2_r <= 1'b0;
         vm_s3_r <= 1'b0;
      end else begin
         vm_s1_r <= vm_opt_in;
         vm_s2_r <= vm_s1_r;
         vm_s3_r <= vm_s2_r;
      end
   end

   // A strap bouncing between stages keeps the old option value
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         vm_opt_r <= 1'b0;
      end else if (vm_agree) begin
         vm_opt_r <= vm_s3_r;
      end
   end

   // Combinational decode of the incoming request
   logic [4:0]  grp_w;
   logic [15:0] idx_w;
   prsd_cat_t   cat_w;

   prsd_group_sel u_group_sel (
      .addr_in (req_in.addr),
      .grp_out (grp_w),
      .idx_out (idx_w)
   );

   // Upper bits of normal addresses are ignored, not faulted
   wire [7:0] num_w = req_in.addr[7:0];

   prsd_class_lut u_class_lut (
      .num_in  (num_w),
      .cat_out (cat_w)
   );

   wire normal_w = grp_w[`PRSD_G_NORMAL];
   wire cls_ext  = (cat_w.cls == `PRSD_CLS_EXT);
   wire sub_uc   = (cat_w.sub == 3'h1);
   wire sub_mmu  = (cat_w.sub == 3'h2);
   wire sub_cf   = (cat_w.sub == 3'h3);
   wire sub_vm   = (cat_w.sub == 3'h4);
   wire sub_cmd  = (cat_w.sub == 3'h5);
   wire sub_rsv  = (cat_w.sub == 3'h6);
   wire sub_tmr  = (cat_w.sub == 3'h7);

   // Routing of the current reference
   wire go_ext  = normal_w && cls_ext;
   wire go_uc   = normal_w && !cls_ext &&
                  (sub_uc || (sub_vm && vm_opt_r));
   wire go_cf   = normal_w && !cls_ext &&
                  (sub_cf || (sub_vm && !vm_opt_r));
   wire go_icmd = normal_w && !cls_ext &&
                  (sub_mmu || sub_cmd || sub_tmr);
   wire go_rsv  = normal_w && !cls_ext && sub_rsv;
   wire fwd_w   = go_ext || go_cf;

   // Only the register number enters the I/O window
   wire [31:0] io_addr_w = `PRSD_IO_BASE |
                           {22'h00_0000, num_w, 2'h0};

   wire req_take = req_valid_in && (state_r == ST_IDLE);

   // Captured reference
   prsd_req_t req_r;
   prsd_dec_t dec_r;
   logic      dvalid_r;
   logic      r_uc_r;
   logic      r_cf_r;
   logic      r_ext_r;
   logic      r_rsv_r;
   logic      r_mmu_r;

   // One-cycle pulse marks the decode result
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         dvalid_r <= 1'b0;
      end else begin
         dvalid_r <= req_take;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         req_r <= '0;
         dec_r <= '0;
      end else if (req_take) begin
         req_r         <= req_in;
         dec_r.grp     <= grp_w;
         dec_r.fwd     <= fwd_w;
         dec_r.num     <= num_w;
         dec_r.idx     <= idx_w;
         dec_r.io_addr <= fwd_w ? io_addr_w : `PRSD_ZERO32;
      end
   end

   // Route flags frozen per reference, so a late strap move cannot reroute it
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         r_uc_r  <= 1'b0;
         r_cf_r  <= 1'b0;
         r_ext_r <= 1'b0;
         r_rsv_r <= 1'b0;
         r_mmu_r <= 1'b0;
      end else if (req_take) begin
         r_uc_r  <= go_uc;
         r_cf_r  <= go_cf;
         r_ext_r <= go_ext;
         r_rsv_r <= go_rsv;
         r_mmu_r <= normal_w && sub_mmu;
      end
   end

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (req_valid_in) begin
               state_nxt = ST_ROUTE;
            end
         end
         ST_ROUTE: begin
            if (r_ext_r) begin
               state_nxt = ST_BUS;
            end else if (r_uc_r) begin
               state_nxt = ST_UCODE;
            end else if (r_rsv_r) begin
               state_nxt = ST_DONE;
            end else begin
               state_nxt = ST_ICMD;
            end
         end
         ST_UCODE: begin
            if (ucode_done_in) begin
               state_nxt = ST_DONE;
            end
         end
         ST_ICMD: begin
            if (icmd_done_in) begin
               state_nxt = r_cf_r ? ST_BUS : ST_DONE;
            end
         end
         ST_BUS: begin
            if (bus_ready_in) begin
               state_nxt = req_r.write ? ST_DONE : ST_RSP;
            end
         end
         ST_RSP: begin
            if (bus_rsp_valid_in) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Read data capture
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        rsv_hit_r;

   wire uc_fin  = (state_r == ST_UCODE) && ucode_done_in;
   wire ic_fin  = (state_r == ST_ICMD) && icmd_done_in && !r_cf_r;
   wire rsp_fin = (state_r == ST_RSP) && bus_rsp_valid_in;
   wire rsv_fin = (state_r == ST_ROUTE) && r_rsv_r;

   // Reserved entries read back as zero rather than stale data
   assign rdata_nxt = uc_fin  ? ucode_rdata_in  :
                      ic_fin  ? icmd_rdata_in   :
                      rsp_fin ? bus_rsp_data_in :
                      (rsv_fin || req_take) ? `PRSD_ZERO32 : rdata_r;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rdata_r <= `PRSD_ZERO32;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Hit flag stands until the next accept so it can be looked at late
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rsv_hit_r <= 1'b0;
      end else if (req_take) begin
         rsv_hit_r <= 1'b0;
      end else if (rsv_fin) begin
         rsv_hit_r <= 1'b1;
      end
   end

   // Outgoing command registers, loaded while routing
   prsd_icmd_t icmd_r;
   prsd_bus_t  bus_r;
   logic [7:0] ucnum_r;

   // Cache groups carry their entry index, normal ones their number
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         icmd_r <= '0;
      end else if (state_r == ST_ROUTE) begin
         icmd_r.write <= req_r.write;
         icmd_r.mmu   <= r_mmu_r;
         icmd_r.grp   <= dec_r.grp;
         icmd_r.num   <= dec_r.num;
         icmd_r.idx   <= dec_r.idx;
         icmd_r.wdata <= req_r.wdata;
      end
   end

   // Read commands carry zero data so nothing stale leaks onto the bus
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         bus_r <= '0;
      end else if (state_r == ST_ROUTE) begin
         bus_r.write <= req_r.write;
         bus_r.addr  <= dec_r.io_addr;
         bus_r.data  <= req_r.write ? req_r.wdata : `PRSD_ZERO32;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ucnum_r <= 8'h00;
      end else if (state_r == ST_ROUTE) begin
         ucnum_r <= dec_r.num;
      end
   end

   // Bus request only ever leaves for forwarded normal registers
   assign bus_valid_out   = (state_r == ST_BUS) && dec_r.fwd;
   assign bus_out         = bus_r;
   assign icmd_valid_out  = (state_r == ST_ICMD);
   assign icmd_out        = icmd_r;
   assign ucode_valid_out = (state_r == ST_UCODE);
   assign ucode_num_out   = ucnum_r;

   assign req_ready_out = (state_r == ST_IDLE);
   assign dec_valid_out = dvalid_r;
   assign dec_out       = dec_r;
   assign done_out      = (state_r == ST_DONE);
   assign rdata_out     = rdata_r;
   assign rsvd_hit_out  = rsv_hit_r;

endmodule

// ===== verification/prsd_decoder_properties.sv
`timescale 1ns/1ns
module prsd_decoder_properties
   import prsd_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // Request and completion
   input  wire logic       req_valid_in,
   input  wire logic       req_ready_out,
   input  wire prsd_req_t  req_in,
   input  wire logic       done_out,
   input  wire logic       rsvd_hit_out,
   // Decode and paths
   input  wire logic       dec_valid_out,
   input  wire prsd_dec_t  dec_out,
   input  wire logic       ucode_valid_out,
   input  wire logic       ucode_done_in,
   input  wire logic       bus_valid_out,
   input  wire prsd_bus_t  bus_out,
   input  wire logic       bus_ready_in
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic take;
   logic inner_r;
   assign take = req_valid_in && req_ready_out;
   // Held from decode to done, so a late bus request on a cache group is caught
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in || done_out)
         inner_r <= 1'b0;
      else if (dec_valid_out)
         inner_r <= !dec_out.grp[0];
   end
   chk_dec_after_take: assert property (take |=> dec_valid_out && !req_ready_out)
      else $error("decode did not follow accept");
   chk_grp_onehot: assert property (dec_valid_out |-> $onehot(dec_out.grp))
      else $error("group select not one-hot");
   chk_normal_sel: assert property (take && !req_in.addr[24] |=>
      dec_out.grp == 5'h01 && dec_out.num == $past(req_in.addr[7:0])) else $error("normal decode wrong");
   chk_l2_tag_idx: assert property (take && req_in.addr[24:22] == 3'b100 |=>
      dec_out.grp == 5'h02 && dec_out.idx == $past(req_in.addr[20:5])) else $error("l2 tag decode wrong");
   chk_l1_par_idx: assert property (take && req_in.addr[24:22] == 3'b111 |=>
      dec_out.grp == 5'h10 && dec_out.idx == {6'h00, $past(req_in.addr[12:3])}) else $error("l1 parity wrong");
   chk_no_bus_inner: assert property (!(inner_r && bus_valid_out))
      else $error("cache group reached the bus");
   chk_io_addr_form: assert property (dec_valid_out && dec_out.fwd |->
      dec_out.io_addr == (32'hE100_0000 | {22'h0, dec_out.num, 2'b00})) else $error("io address wrong");
   chk_bus_from_dec: assert property (bus_valid_out |-> dec_out.fwd && bus_out.addr == dec_out.io_addr)
      else $error("bus command without forward");
   chk_bus_held: assert property (bus_valid_out && !bus_ready_in |=> bus_valid_out && $stable(bus_out))
      else $error("bus command dropped early");
   chk_class3_fwd: assert property (dec_valid_out && dec_out.grp[0] && dec_out.num[7:5] == 3'b100 |->
      dec_out.fwd) else $error("unimplemented register not forwarded");
   chk_ucode_local: assert property (dec_valid_out && dec_out.grp[0] && dec_out.num < 8'h05 |->
      !dec_out.fwd ##1 ucode_valid_out) else $error("microcode path not taken");
   chk_rsvd_done: assert property (dec_valid_out && dec_out.grp[0] && dec_out.num == 8'hFF |=>
      done_out && rsvd_hit_out) else $error("reserved register not completed");
   cov_bus_read: cover property (bus_valid_out && bus_ready_in && !bus_out.write);
   cov_ucode: cover property (ucode_valid_out && ucode_done_in);
   cov_rsvd: cover property (done_out && rsvd_hit_out);
endmodule

bind prsd_decoder prsd_decoder_properties i_chk (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
   .req_ready_out(req_ready_out), .req_in(req_in), .done_out(done_out), .rsvd_hit_out(rsvd_hit_out),
   .dec_valid_out(dec_valid_out), .dec_out(dec_out), .ucode_valid_out(ucode_valid_out),
   .ucode_done_in(ucode_done_in), .bus_valid_out(bus_valid_out), .bus_out(bus_out), .bus_ready_in(bus_ready_in)
);

// ===== verification/prsd_sys_env.sv
`timescale 1ns/1ns
module prsd_sys_env
   import prsd_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   // System bus
   input  wire logic       bus_valid_in,
   input  wire prsd_bus_t  bus_in,
   output logic            bus_ready_out = 1'b0,
   output logic            rsp_valid_out = 1'b0,
   output logic     [31:0] rsp_data_out = 32'h0000_0000
);
   logic        pend = 1'b0;
   logic [31:0] pa = 32'h0000_0000;
   int          w = 0;
   // Takes reads and writes, answers reads after a random wait
   always @(posedge core_clk_in) begin
      bus_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      // Idle data toggles so a stale sample never matches
      rsp_data_out <= ~rsp_data_out;
      if (!rst_n_in)
         pend <= 1'b0;
      else if (pend) begin
         if (w == 0) begin
            rsp_valid_out <= 1'b1;
            rsp_data_out <= pa ^ 32'h5A5A_A5A5;
            pend <= 1'b0;
         end
         else
            w <= w - 1;
      end
      else if (bus_valid_in && !bus_ready_out && $urandom_range(0, 2) == 0) begin
         bus_ready_out <= 1'b1;
         pend <= !bus_in.write;
         pa <= bus_in.addr;
         w <= $urandom_range(0, 3);
      end
   end
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ns
module tb;
   import prsd_pkg::*;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        vm_opt_in = 1'b0;
   logic        req_valid_in = 1'b0;
   prsd_req_t   req_in = '0;
   logic        ucode_done_in = 1'b0;
   logic        icmd_done_in = 1'b0;
   logic [31:0] ucode_rdata_in = 32'h0000_0000;
   logic [31:0] icmd_rdata_in = 32'h0000_0000;
   logic        bus_ready_in, bus_rsp_valid_in, req_ready_out, done_out, rsvd_hit_out;
   logic        dec_valid_out, ucode_valid_out, icmd_valid_out, bus_valid_out;
   logic [31:0] bus_rsp_data_in, rdata_out;
   logic [7:0]  ucode_num_out;
   prsd_dec_t   dec_out;
   prsd_icmd_t  icmd_out;
   prsd_bus_t   bus_out;
   int          miscompares = 0;
   int          check_count = 0;
   int          n;

   prsd_decoder i_dut (.*);
   prsd_sys_env i_env (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_valid_in(bus_valid_out),
      .bus_in(bus_out), .bus_ready_out(bus_ready_in), .rsp_valid_out(bus_rsp_valid_in),
      .rsp_data_out(bus_rsp_data_in));

   initial begin
      forever #25 core_clk_in = ~core_clk_in;
   end

   // Path kinds: 0 microcode, 1 command, 2 command then bus, 3 bus, 4 reserved, 5 mmu command
   function automatic int path(input logic [7:0] r, input logic vm);
      if (r inside {[0:4], 'h0E, ['h10:'h15], 'h26, 'h2A, 'h2B, 'h39, 'h3A, 'h3E, 'h3F, ['h7A:'h7F]})
         return 0;
      if (r inside {[8:13], 'h38})
         return 5;
      if (r inside {'h18, 'hA0, ['hA2:'hA8], 'hAB, 'hAC, 'hAE, 'hB0, 'hB2, 'hB4, 'hB6, 'hB8, ['hD0:'hD4],
                    'hD6, 'hD7, ['hE0:'hEA], 'hEC, 'hED, 'hF2, 'hF4, 'hF8})
         return 1;
      if (r inside {['h1B:'h23], 'h37, ['h40:'h44]})
         return 2;
      if (r inside {['h64:'h66]})
         return vm ? 0 : 2;
      return r >= 8'hA0 ? 4 : 3;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic run(input logic [31:0] a, input logic w);
      logic [31:0] wd, ed, r, io;
      logic [15:0] ix;
      int          k, i;
      bit          f, fin, bus, pu, pi, su, si;
      wd = $urandom;
      k = a[24] ? 1 : path(a[7:0], vm_opt_in);
      f = !a[24] && (k == 2 || k == 3);
      io = 32'hE100_0000 + {22'h0, a[7:0], 2'b00};
      ix = a[23] ? (a[22] ? {6'h00, a[12:3]} : {8'h00, a[12:5]}) : a[20:5];
      ed = 32'h0000_0000;
      {fin, bus, su, si} = 4'h0;
      @(posedge core_clk_in);
      req_valid_in <= 1'b1;
      req_in <= '{w, a, wd};
      @(negedge core_clk_in);
      chk("ready", 1'b1, req_ready_out);
      @(posedge core_clk_in);
      req_valid_in <= 1'b0;
      for (i = 1; i < 60 && !fin; i++) begin
         @(negedge core_clk_in);
         r = $urandom;
         if (i == 1) begin
            chk("dec_valid", 1'b1, dec_valid_out);
            chk("num", a[7:0], dec_out.num);
            chk("grp", a[24] ? 5'h02 << a[23:22] : 5'h01, dec_out.grp);
            chk("fwd", f, dec_out.fwd);
            chk("io_addr", f ? io : 32'h0000_0000, dec_out.io_addr);
            if (a[24])
               chk("idx", ix, dec_out.idx);
         end
         if (bus_valid_out === 1'b1 && !bus) begin
            bus = 1;
            chk("bus_addr", io, bus_out.addr);
            chk("bus_data", w ? wd : 32'h0000_0000, bus_out.data);
            chk("bus_wr", w, bus_out.write);
            ed = io ^ 32'h5A5A_A5A5;
         end
         if (done_out === 1'b1) begin
            fin = 1;
            chk("bus_seen", f, bus);
            chk("ucode_seen", k == 0, su);
            chk("icmd_seen", k == 1 || k == 2 || k == 5, si);
            chk("rsvd", k == 4, rsvd_hit_out);
            if (k == 4)
               chk("rsvd_lat", 32'h0000_0002, i);
            if (!w)
               chk("rdata", ed, rdata_out);
         end
         pu = ucode_valid_out === 1'b1 && !ucode_done_in && $urandom_range(0, 1) == 0;
         pi = icmd_valid_out === 1'b1 && !icmd_done_in && $urandom_range(0, 1) == 0;
         if (pu) begin
            su = 1;
            ed = r;
            chk("ucode_num", a[7:0], ucode_num_out);
         end
         if (pi) begin
            si = 1;
            ed = r;
            chk("mmu", k == 5, icmd_out.mmu);
            chk("icmd_wr", w, icmd_out.write);
            chk("icmd_grp", a[24] ? 5'h02 << a[23:22] : 5'h01, icmd_out.grp);
            chk("icmd_idx", a[24] ? ix : 16'h0000, icmd_out.idx);
         end
         @(posedge core_clk_in);
         ucode_done_in <= pu;
         icmd_done_in <= pi;
         ucode_rdata_in <= r;
         icmd_rdata_in <= r;
      end
      if (!fin) begin
         miscompares++;
         end_of_test();
      end
   endtask

   initial begin
      n = $urandom(32'h550E_EA1C);
      repeat (8) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      for (n = 0; n < 256; n++)
         run(n, $urandom_range(0, 1));
      $display("Test normal group sweep done");
      @(posedge core_clk_in);
      vm_opt_in <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      for (n = 'h60; n < 'h70; n++)
         run(($urandom & 32'hFEFF_FF00) | n, $urandom_range(0, 1));
      $display("Test vm option done");
      for (n = 0; n < 64; n++)
         run(32'h0100_0000 | ($urandom & 32'h00FF_FFFF), n[0]);
      run(32'h011F_FFE0, 1'b0);
      run(32'h015F_FFE0, 1'b1);
      run(32'h0180_1FE0, 1'b0);
      run(32'h01C0_1FF8, 1'b1);
      $display("Test cache groups done");
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(negedge core_clk_in);
      chk("rst_ready", 1'b1, req_ready_out);
      chk("rst_bus", 1'b0, bus_valid_out);
      run(32'h0000_0019, 1'b0);
      $display("Test second reset done");
      end_of_test();
   end
endmodule
